// *** rtl/aos_output_stage.sv ***
`timescale 1ns/1ps
module aos_output_stage (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // fault flags and angle from the signal path
  input wire logic [12:0] fault_flags,
  input wire logic [13:0] angle_raw,
  input wire logic [13:0] angle_hyst,
  input wire logic [7:0] pwm_angle_duty,
  // pwm pin
  output logic pwm_out,
  output logic pwm_oe,
  // quadrature pins
  output logic quad_a,
  output logic quad_b,
  output logic quad_i,
  output logic quad_oe
);

  logic [23:0] err_mask_q;
  logic [23:0] quad_ctrl_q;
  logic [23:0] iface_ctrl_q;
  logic waitreq_q;
  logic [31:0] rdata_q;
  logic [7:0] cnt_q;
  logic pwm_q;
  logic pwm_oe_q;
  logic [13:0] pos_q;
  logic [9:0] gap_q;
  logic a_q;
  logic b_q;
  logic i_q;
  logic quad_oe_q;

  logic [7:0] reg_idx;
  logic bus_req;
  logic bus_done;
  logic [12:0] hit;
  logic any_hit;
  logic [3:0] top_idx;
  logic [7:0] duty_sel;
  logic respond_en;
  logic style_sel;
  logic pen;
  logic [4:0] slew_n;
  logic [9:0] spacing;
  logic flip;
  logic [1:0] imode;
  logic incremental_out_en;
  logic comm;
  logic [3:0] res_n;
  logic [3:0] shift;
  logic [13:0] mask;
  logic [13:0] angle_sel;
  logic [13:0] target;
  logic [13:0] diff;
  logic step_ok;
  logic [13:0] pos_d;
  logic idx_hit;
  logic [1:0] ab_plain;

  assign reg_idx = {2'h0, avs_address[7:2]};
  assign bus_req = avs_read | avs_write;
  assign bus_done = bus_req & ~waitreq_q;

  // one wait cycle per access; the answer edge is the one after the first
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      waitreq_q <= 1'b1;
    else if (bus_req && waitreq_q)
      waitreq_q <= 1'b0;
    else
      waitreq_q <= 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rdata_q <= 32'h00000000;
    else if (avs_read && waitreq_q)
    begin
      case (reg_idx)
        aos_pkg::REG_PWM_ERR_ENABLE_MASK: rdata_q <= {8'h00, err_mask_q};
        aos_pkg::REG_QUAD_OUTPUT_CONTROL: rdata_q <= {8'h00, quad_ctrl_q};
        aos_pkg::REG_PWM_IFACE_CTRL: rdata_q <= {8'h00, iface_ctrl_q};
        aos_pkg::REG_OUTPUT_STATUS: rdata_q <= {3'h0, quad_oe_q, i_q, b_q, a_q, pwm_oe_q, any_hit, top_idx, pos_q,
                                                 3'h0, pwm_q, 1'b0};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  // writes land only on the edge where waitrequest is seen low
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      err_mask_q <= aos_pkg::RST_PWM_ERR_ENABLE_MASK;
      quad_ctrl_q <= aos_pkg::RST_QUAD_OUTPUT_CONTROL;
      iface_ctrl_q <= aos_pkg::RST_PWM_IFACE_CTRL;
    end
    else if (bus_done && avs_write)
    begin
      if (reg_idx == aos_pkg::REG_PWM_ERR_ENABLE_MASK)
        err_mask_q <= avs_writedata[23:0] & aos_pkg::ERR_MASK_BITS;
      if (reg_idx == aos_pkg::REG_QUAD_OUTPUT_CONTROL)
        quad_ctrl_q <= avs_writedata[23:0];
      if (reg_idx == aos_pkg::REG_PWM_IFACE_CTRL)
        iface_ctrl_q <= avs_writedata[23:0];
    end
  end

  assign respond_en = iface_ctrl_q[aos_pkg::PWI_RESPOND_BIT];
  assign style_sel = iface_ctrl_q[aos_pkg::PWI_STYLE_BIT];
  assign pen = iface_ctrl_q[aos_pkg::PWI_PEN_BIT];

  // per-fault gating by its enable bit
  genvar gi;
  generate
    for (gi = 0; gi < aos_pkg::NUM_FAULTS; gi++)
    begin : g_hit
      assign hit[gi] = fault_flags[gi] & err_mask_q[gi];
    end
  endgenerate

  assign any_hit = |hit;

  // highest bit wins; duty = base + step * bit gives 5% .. 72.5%
  always_comb
  begin
    top_idx = 4'h0;
    for (int k = 0; k < aos_pkg::NUM_FAULTS; k++)
    begin
      if (hit[k])
        top_idx = 4'(k);
    end
  end

  assign duty_sel = (respond_en && style_sel && any_hit) ?
                    8'(aos_pkg::PWM_DUTY_BASE + aos_pkg::PWM_DUTY_STEP * {4'h0, top_idx}) : pwm_angle_duty;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      cnt_q <= 8'h00;
    else if (cnt_q == aos_pkg::PWM_PERIOD - 8'h01)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_q + 8'h01;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pwm_q <= 1'b0;
      pwm_oe_q <= 1'b0;
    end
    else
    begin
      pwm_q <= cnt_q < duty_sel;
      pwm_oe_q <= pen && !(respond_en && !style_sel && any_hit);
    end
  end

  assign slew_n = quad_ctrl_q[aos_pkg::QOC_SLEW_MSB:aos_pkg::QOC_SLEW_LSB];
  assign spacing = 10'({5'h00, slew_n} + 10'h001) * aos_pkg::SLEW_UNIT_CYC;
  assign flip = quad_ctrl_q[aos_pkg::QOC_FLIP_BIT];
  assign imode = quad_ctrl_q[aos_pkg::QOC_INDEX_MSB:aos_pkg::QOC_INDEX_LSB];
  assign incremental_out_en = quad_ctrl_q[aos_pkg::QOC_IOE_BIT];
  assign comm = quad_ctrl_q[aos_pkg::QOC_COMM_BIT];
  assign res_n = quad_ctrl_q[aos_pkg::QOC_RES_MSB:aos_pkg::QOC_RES_LSB];

  // codes without a defined AB rate are held at the finest one
  assign shift = (res_n < aos_pkg::RES_MIN) ? 4'h1 : res_n - 4'h2;
  // four states per AB cycle: 2^(16-n) states per turn
  assign mask = 14'h3fff >> shift;
  assign angle_sel = quad_ctrl_q[aos_pkg::QOC_HYST_BIT] ? angle_hyst : angle_raw;
  assign target = angle_sel >> shift;
  assign diff = (target - pos_q) & mask;
  // position moves one state per allowed edge, so a fast turn lags rather than skips states
  assign step_ok = (slew_n == 5'h00) || (gap_q >= spacing - 10'h001);

  always_comb
  begin
    pos_d = pos_q;
    if (diff != 14'h0000 && step_ok)
    begin
      if (diff > (mask >> 1))
        pos_d = (pos_q - 14'h0001) & mask;
      else
        pos_d = (pos_q + 14'h0001) & mask;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      pos_q <= 14'h0000;
    else
      pos_q <= pos_d & mask;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      gap_q <= 10'h000;
    else if (pos_d != pos_q)
      gap_q <= 10'h000;
    else if (gap_q != 10'h3ff)
      gap_q <= gap_q + 10'h001;
  end

  assign ab_plain = {pos_q[1], pos_q[1] ^ pos_q[0]};

  always_comb
  begin
    case (imode)
      aos_pkg::IDX_0_P1: idx_hit = pos_q == 14'h0000;
      aos_pkg::IDX_M1_P1: idx_hit = (pos_q == 14'h0000) || (pos_q == mask);
      aos_pkg::IDX_M1_P2: idx_hit = (pos_q <= 14'h0001) || (pos_q == mask);
      default: idx_hit = (pos_q <= 14'h0001) || (pos_q >= mask - 14'h0001);
    endcase
  end

  // commutation waveforms are not produced here; that mode keeps the pins idle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      i_q <= 1'b0;
      quad_oe_q <= 1'b0;
    end
    else if (incremental_out_en && !comm)
    begin
      a_q <= ab_plain[1] ^ flip;
      b_q <= ab_plain[0] ^ flip;
      i_q <= idx_hit ^ flip;
      quad_oe_q <= 1'b1;
    end
    else
    begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      i_q <= 1'b0;
      quad_oe_q <= 1'b0;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = waitreq_q;
  assign pwm_out = pwm_q;
  assign pwm_oe = pwm_oe_q;
  assign quad_a = a_q;
  assign quad_b = b_q;
  assign quad_i = i_q;
  assign quad_oe = quad_oe_q;

  a_wait_one: assert property (@(posedge clk_sys) disable iff (reset)
    (bus_req && waitreq_q) |=> !waitreq_q ##1 waitreq_q)
    else $error("waitrequest did not drop for exactly one cycle");

  a_pwm_tristate: assert property (@(posedge clk_sys) disable iff (reset)
    (pen && respond_en && !style_sel && any_hit) |=> !pwm_oe_q)
    else $error("pwm not tristated for fault in tristate style");

  a_pwm_ignore: assert property (@(posedge clk_sys) disable iff (reset)
    (pen && !respond_en) |=> pwm_oe_q && (pwm_q == ($past(cnt_q) < $past(pwm_angle_duty))))
    else $error("pwm reacted to faults with respond disabled");

  a_fault_duty: assert property (@(posedge clk_sys) disable iff (reset)
    (respond_en && style_sel && hit[12] && cnt_q == 8'h73) |=>
      pwm_q ##1 (!pwm_q || $past(!(respond_en && style_sel && hit[12]))))
    else $error("top fault duty edge not at 116 of 160");

  a_oscillator_duty: assert property (@(posedge clk_sys) disable iff (reset)
    (respond_en && style_sel && hit == 13'h0001 && cnt_q == 8'h08) |=> !pwm_q)
    else $error("oscillator fault duty not 8 of 160");

  a_slew_gap: assert property (@(posedge clk_sys) disable iff (reset)
    (pos_d != pos_q && slew_n != 5'h00) |-> gap_q >= spacing - 10'h001)
    else $error("quadrature edge came too soon");

  a_single_step: assert property (@(posedge clk_sys) disable iff (reset)
    ($changed(pos_q) && $stable(mask) && $past(pos_q) <= mask) |->
      (((pos_q - $past(pos_q)) & mask) == 14'h0001 || ((pos_q - $past(pos_q)) & mask) == mask))
    else $error("quadrature position skipped a state");

  a_quad_off: assert property (@(posedge clk_sys) disable iff (reset)
    !incremental_out_en |=> !quad_oe_q && !a_q && !b_q && !i_q)
    else $error("quadrature pins active while disabled");

  a_ab_state: assert property (@(posedge clk_sys) disable iff (reset)
    (incremental_out_en && !comm && pos_q[1:0] == 2'h2) |=> (a_q == !$past(flip)) && (b_q == !$past(flip)))
    else $error("third quadrature state wrong");

  a_index_zero: assert property (@(posedge clk_sys) disable iff (reset)
    (incremental_out_en && !comm && imode == aos_pkg::IDX_0_P1 && pos_q == 14'h0001) |=> (i_q == $past(flip)))
    else $error("index pulse outside window code 0");

  a_index_one: assert property (@(posedge clk_sys) disable iff (reset)
    (incremental_out_en && !comm && imode == aos_pkg::IDX_M1_P1 && pos_q == mask) |=> (i_q == !$past(flip)))
    else $error("index pulse missing one step below zero");

  a_mask_write: assert property (@(posedge clk_sys) disable iff (reset)
    (bus_done && avs_write && reg_idx == aos_pkg::REG_PWM_ERR_ENABLE_MASK) |=>
      (err_mask_q == ($past(avs_writedata[23:0]) & aos_pkg::ERR_MASK_BITS)))
    else $error("enable mask write did not land");

  a_mask_readback: assert property (@(posedge clk_sys) disable iff (reset)
    (avs_read && waitreq_q && reg_idx == aos_pkg::REG_PWM_ERR_ENABLE_MASK) |=>
      (!avs_waitrequest && avs_readdata == {8'h00, $past(err_mask_q)}))
    else $error("enable mask read back wrong");

  a_soft_high: assert property (@(posedge clk_sys) disable iff (reset)
    (respond_en && style_sel && hit[12:8] == 5'h01 && cnt_q == 8'h4f) |=> pwm_q)
    else $error("soft error duty ended before 80 of 160");

  a_soft_low: assert property (@(posedge clk_sys) disable iff (reset)
    (respond_en && style_sel && hit[12:8] == 5'h01 && cnt_q == 8'h50) |=> !pwm_q)
    else $error("soft error duty ran past 80 of 160");

  a_pwm_enabled: assert property (@(posedge clk_sys) disable iff (reset)
    (pen && !any_hit) |=> pwm_oe_q)
    else $error("pwm pin not driven while enabled");

  a_quad_on: assert property (@(posedge clk_sys) disable iff (reset)
    (incremental_out_en && !comm) |=> quad_oe_q)
    else $error("quadrature pins not driven while enabled");

  a_comm_idle: assert property (@(posedge clk_sys) disable iff (reset)
    (incremental_out_en && comm) |=> !quad_oe_q && !a_q && !b_q && !i_q)
    else $error("quadrature pins active in commutation mode");

  a_first_state: assert property (@(posedge clk_sys) disable iff (reset)
    (incremental_out_en && !comm && pos_q[1:0] == 2'h0) |=> (a_q == $past(flip)) && (b_q == $past(flip)))
    else $error("first quadrature state wrong");

  a_slew_off: assert property (@(posedge clk_sys) disable iff (reset)
    (slew_n == 5'h00 && diff != 14'h0000) |=> $changed(pos_q))
    else $error("position held back with slew limiting off");

endmodule

// *** inc/aos_pkg.sv ***
package aos_pkg;
  // register indexes; byte address on the bus is four times the index
  localparam logic [7:0] REG_PWM_ERR_ENABLE_MASK = 8'h18;
  localparam logic [7:0] REG_QUAD_OUTPUT_CONTROL = 8'h19;
  localparam logic [7:0] REG_PWM_IFACE_CTRL = 8'h1b;
  localparam logic [7:0] REG_OUTPUT_STATUS = 8'h20;
  // reset values
  localparam logic [23:0] RST_PWM_ERR_ENABLE_MASK = 24'h000000;
  localparam logic [23:0] RST_QUAD_OUTPUT_CONTROL = 24'h081024;
  localparam logic [23:0] RST_PWM_IFACE_CTRL = 24'h670100;
  localparam logic [23:0] ERR_MASK_BITS = 24'h001fff;
  // pwm_iface_ctrl fields
  localparam int PWI_PEN_BIT = 23;
  localparam int PWI_RESPOND_BIT = 13;
  localparam int PWI_STYLE_BIT = 12;
  // quadrature_output_control fields
  localparam int QOC_SLEW_LSB = 16;
  localparam int QOC_SLEW_MSB = 20;
  localparam int QOC_FLIP_BIT = 15;
  localparam int QOC_HYST_BIT = 12;
  localparam int QOC_INDEX_LSB = 8;
  localparam int QOC_INDEX_MSB = 9;
  localparam int QOC_IOE_BIT = 5;
  localparam int QOC_COMM_BIT = 4;
  localparam int QOC_RES_LSB = 0;
  localparam int QOC_RES_MSB = 3;
  // fault inputs, one per enable bit
  localparam int NUM_FAULTS = 13;
  // pwm carrier: 160 counts make every coded duty an exact count
  localparam logic [7:0] PWM_PERIOD = 8'ha0;
  localparam logic [7:0] PWM_DUTY_BASE = 8'h08;
  localparam logic [7:0] PWM_DUTY_STEP = 8'h09;
  // slew timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SLEW_UNIT_PS = 125000;
  localparam logic [9:0] SLEW_UNIT_CYC = 10'(SLEW_UNIT_PS / CLK_PERIOD_PS);
  // smallest usable resolution code
  localparam logic [3:0] RES_MIN = 4'h3;
  // index window codes
  localparam logic [1:0] IDX_0_P1 = 2'h0;
  localparam logic [1:0] IDX_M1_P1 = 2'h1;
  localparam logic [1:0] IDX_M1_P2 = 2'h2;
endpackage

// *** testbench/aos_host_model.sv ***
`timescale 1ns/1ps
module aos_host_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // observed pins
  input wire logic pwm_out,
  input wire logic quad_a,
  input wire logic quad_b,
  // restart of the edge statistics
  input wire logic clr,
  // decoded results
  output logic [7:0] duty_seen,
  output logic [15:0] edge_count,
  output logic [15:0] min_gap
);
  logic [7:0] win_q;
  logic [7:0] high_q;
  logic [15:0] gap_q;
  logic [1:0] ab_q;
  logic seen_q;

  // a steady waveform gives the same high count in any window of one carrier period
  always_ff @(posedge clk_sys)
  begin
    if (reset || win_q == aos_pkg::PWM_PERIOD - 8'h01)
    begin
      win_q <= 8'h00;
      high_q <= 8'(pwm_out);
      duty_seen <= reset ? 8'h00 : high_q;
    end
    else
    begin
      win_q <= win_q + 8'h01;
      high_q <= high_q + 8'(pwm_out);
    end
  end

  // gaps only count between two edges, not from the restart to the first edge
  always_ff @(posedge clk_sys)
  begin
    ab_q <= {quad_a, quad_b};
    if (reset || clr)
    begin
      edge_count <= 16'h0000;
      min_gap <= 16'hffff;
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end
    else if ({quad_a, quad_b} != ab_q)
    begin
      edge_count <= edge_count + 16'h0001;
      if (seen_q && gap_q + 16'h0001 < min_gap)
        min_gap <= gap_q + 16'h0001;
      gap_q <= 16'h0000;
      seen_q <= 1'b1;
    end
    else if (gap_q != 16'hffff)
      gap_q <= gap_q + 16'h0001;
  end
endmodule

// *** testbench/test_angle_output_stage.sv ***
`timescale 1ns/1ps
module test_angle_output_stage;
  typedef struct {logic [31:0] mask; logic [12:0] flags; logic [7:0] duty;} aos_row_type;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [12:0] fault_flags = 13'h0000;
  logic [13:0] angle_raw = 14'h0000;
  logic [13:0] angle_hyst = 14'h0000;
  logic [7:0] pwm_angle_duty = 8'h30;
  logic pwm_out, pwm_oe, quad_a, quad_b, quad_i, quad_oe;
  logic clr = 1'b0;
  logic [7:0] duty_seen;
  logic [15:0] edge_count, min_gap;
  logic [31:0] rd;
  int fails = 0;
  int cmp_count = 0;
  aos_row_type rows[15];

  always #2.5 clk_sys = ~clk_sys;

  aos_output_stage dut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fault_flags(fault_flags), .angle_raw(angle_raw),
    .angle_hyst(angle_hyst), .pwm_angle_duty(pwm_angle_duty), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
    .quad_a(quad_a), .quad_b(quad_b), .quad_i(quad_i), .quad_oe(quad_oe));

  aos_host_model host (.clk_sys(clk_sys), .reset(reset), .pwm_out(pwm_out), .quad_a(quad_a), .quad_b(quad_b),
    .clr(clr), .duty_seen(duty_seen), .edge_count(edge_count), .min_gap(min_gap));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // waits on waitrequest, never on a fixed latency
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk_sys);
    avs_address <= 8'(idx << 2);
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    // a hung slave is caught by the watchdog, not here
    do
    begin
      @(posedge clk_sys);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #300000;
    fails++;
    test_done;
  end

  initial
  begin
    for (int i = 0; i < 13; i++)
      rows[i] = '{32'(1 << i), 13'h1fff, 8'(aos_pkg::PWM_DUTY_BASE + aos_pkg::PWM_DUTY_STEP * i)};
    rows[13] = '{32'h001fff, 13'h0050, 8'h3e};
    rows[14] = '{32'h000005, 13'h1ffa, 8'h30};
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    bus(0, aos_pkg::REG_PWM_ERR_ENABLE_MASK, 32'h0);
    chk(rd, 32'h0);
    bus(0, aos_pkg::REG_QUAD_OUTPUT_CONTROL, 32'h0);
    chk(rd, 32'h081024);
    bus(0, aos_pkg::REG_PWM_IFACE_CTRL, 32'h0);
    chk(rd, 32'h670100);
    bus(0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    chk({quad_oe, quad_a, quad_b, quad_i}, 4'b1001);
    bus(1, aos_pkg::REG_PWM_ERR_ENABLE_MASK, 32'hffffffff);
    bus(0, aos_pkg::REG_PWM_ERR_ENABLE_MASK, 32'h0);
    chk(rd, 32'h001fff);
    bus(1, aos_pkg::REG_PWM_IFACE_CTRL, 32'h803000);
    foreach (rows[k])
    begin
      bus(1, aos_pkg::REG_PWM_ERR_ENABLE_MASK, rows[k].mask);
      fault_flags <= rows[k].flags;
      repeat (400) @(posedge clk_sys);
      chk(duty_seen, rows[k].duty);
      chk(pwm_oe, 1'b1);
    end
    fault_flags <= 13'h1fff;
    bus(1, aos_pkg::REG_PWM_IFACE_CTRL, 32'h801000);
    repeat (400) @(posedge clk_sys);
    chk(duty_seen, 8'h30);
    bus(1, aos_pkg::REG_PWM_IFACE_CTRL, 32'h802000);
    repeat (3) @(posedge clk_sys);
    chk(pwm_oe, 1'b0);
    // slew of 8 from reset: three moves spaced by at least nine units
    clr <= 1'b1;
    angle_hyst <= 14'd12;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (750) @(posedge clk_sys);
    chk(edge_count, 16'd3);
    chk(min_gap >= 9 * aos_pkg::SLEW_UNIT_CYC, 1'b1);
    chk({quad_a, quad_b}, 2'b10);
    bus(0, aos_pkg::REG_OUTPUT_STATUS, 32'h0);
    chk(rd & 32'hfffffffd, 32'h12900060);
    bus(1, aos_pkg::REG_QUAD_OUTPUT_CONTROL, 32'h000024);
    repeat (10) @(posedge clk_sys);
    chk({quad_a, quad_b}, 2'b00);
    bus(1, aos_pkg::REG_QUAD_OUTPUT_CONTROL, 32'h008024);
    repeat (3) @(posedge clk_sys);
    chk({quad_a, quad_b, quad_i}, 3'b110);
    bus(1, aos_pkg::REG_QUAD_OUTPUT_CONTROL, 32'h000025);
    angle_raw <= 14'd8;
    repeat (5) @(posedge clk_sys);
    chk({quad_a, quad_b}, 2'b01);
    for (int c = 0; c < 4; c++)
    begin
      bus(1, aos_pkg::REG_QUAD_OUTPUT_CONTROL, 32'h000024 | (c << 8));
      for (int p = -2; p < 3; p++)
      begin
        angle_raw <= 14'(p * 4);
        repeat (8) @(posedge clk_sys);
        chk(quad_i, p >= (c == 0 ? 0 : c == 3 ? -2 : -1) && p <= (c >= 2 ? 1 : 0));
      end
    end
    bus(1, aos_pkg::REG_QUAD_OUTPUT_CONTROL, 32'h000034);
    repeat (3) @(posedge clk_sys);
    chk({quad_oe, quad_a, quad_b, quad_i}, 4'b0000);
    bus(1, aos_pkg::REG_QUAD_OUTPUT_CONTROL, 32'h000004);
    repeat (3) @(posedge clk_sys);
    chk({quad_oe, quad_a, quad_b, quad_i}, 4'b0000);
    // reset in mid-run: registers and pins return to their reset state
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    bus(0, aos_pkg::REG_PWM_ERR_ENABLE_MASK, 32'h0);
    chk(rd, 32'h0);
    bus(0, aos_pkg::REG_PWM_IFACE_CTRL, 32'h0);
    chk(rd, 32'h670100);
    chk({pwm_oe, quad_oe, quad_a, quad_b, quad_i}, 5'b01001);
    test_done;
  end
endmodule
